// file: core/rgl_pkg.sv
package rgl_pkg;

  // clock rate and the one-millisecond step of the edge delays
  localparam int unsigned RGL_CLK_KHZ   = 25000;
  localparam int unsigned RGL_STEP_MS   = 1;
  localparam int unsigned RGL_MS_CYCLES = RGL_CLK_KHZ * RGL_STEP_MS;

  // register indices; byte address is four times the index
  localparam logic [7:0] RGL_IDX_R4_MASK = 8'h10;
  localparam logic [7:0] RGL_IDX_R4_SRC  = 8'h11;
  localparam logic [7:0] RGL_IDX_R4_DLY  = 8'h12;
  localparam logic [7:0] RGL_IDX_R5_MASK = 8'h13;
  localparam logic [7:0] RGL_IDX_R5_SRC  = 8'h14;
  localparam logic [7:0] RGL_IDX_R5_DLY  = 8'h15;
  localparam logic [7:0] RGL_IDX_STAT    = 8'h20;
  localparam logic [7:0] RGL_IDX_R4_BLK  = 8'h21;
  localparam logic [7:0] RGL_IDX_R5_BLK  = 8'h22;
  localparam int unsigned RGL_NREG       = 6;
  localparam int unsigned RGL_REGS_RAIL  = 3;

  // values after reset, per stored register
  localparam logic [7:0] RGL_RST_R4_MASK = 8'h00;
  localparam logic [7:0] RGL_RST_R4_SRC  = 8'h80;
  localparam logic [7:0] RGL_RST_R4_DLY  = 8'h00;
  localparam logic [7:0] RGL_RST_R5_MASK = 8'h00;
  localparam logic [7:0] RGL_RST_R5_SRC  = 8'h00;
  localparam logic [7:0] RGL_RST_R5_DLY  = 8'h00;

  // field positions
  localparam int unsigned RGL_SRC_LSB   = 2;
  localparam int unsigned RGL_PAIR_BIT  = 1;
  localparam int unsigned RGL_LOAD_SWITCH_B_ONE_BIT  = 0;
  localparam int unsigned RGL_RISE_LSB  = 0;
  localparam int unsigned RGL_FALL_LSB  = 3;

  // edge delay figures in ms
  localparam int unsigned RGL_DLY1_MS = 2;
  localparam int unsigned RGL_DLY2_MS = 4;
  localparam int unsigned RGL_DLY3_MS = 8;
  localparam int unsigned RGL_DLY4_MS = 16;
  localparam int unsigned RGL_DLY5_MS = 24;
  localparam int unsigned RGL_DLY6_MS = 32;
  localparam int unsigned RGL_DLY7_MS = 64;

  typedef enum logic [2:0] {
    RGL_SRC_CONTROL_INPUT_ONE   = 3'h0,
    RGL_SRC_CONTROL_INPUT_TWO   = 3'h1,
    RGL_SRC_CONTROL_INPUT_FIVE   = 3'h2,
    RGL_SRC_CONTROL_INPUT_FOUR   = 3'h3,
    RGL_SRC_CONTROL_INPUT_THREE   = 3'h4,
    RGL_SRC_CTL34  = 3'h5,
    RGL_SRC_CONTROL_INPUT_SIX   = 3'h6,
    RGL_SRC_FORCE  = 3'h7
  } rgl_src_e;

  typedef logic [5:0] rgl_ctl_t;

  typedef struct packed {
    logic pair;
    logic sw_b1;
    logic ldo3;
    logic ldo2;
    logic sw_a1;
    logic rail6;
    logic rail5;
    logic rail4;
    logic rail3;
    logic rail2;
    logic rail1;
  } rgl_pg_s;

  function automatic int unsigned rgl_dly_ms(input logic [2:0] code);
    case (code)
      3'h1:    rgl_dly_ms = RGL_DLY1_MS;
      3'h2:    rgl_dly_ms = RGL_DLY2_MS;
      3'h3:    rgl_dly_ms = RGL_DLY3_MS;
      3'h4:    rgl_dly_ms = RGL_DLY4_MS;
      3'h5:    rgl_dly_ms = RGL_DLY5_MS;
      3'h6:    rgl_dly_ms = RGL_DLY6_MS;
      3'h7:    rgl_dly_ms = RGL_DLY7_MS;
      default: rgl_dly_ms = 0;
    endcase
  endfunction : rgl_dly_ms

endpackage : rgl_pkg

// file: core/rgl_edge_delay.sv
`timescale 1ns/1ps
module rgl_edge_delay
  import rgl_pkg::*;
#(
  parameter int unsigned MS_CYCLES = RGL_MS_CYCLES
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       lvl_in,
  input  wire logic [2:0] rise_code,
  input  wire logic [2:0] fall_code,
  output logic            lvl_out,
  output logic            pending
);

  typedef enum logic [1:0] {
    RGL_D_LO   = 2'b00,
    RGL_D_RISE = 2'b01,
    RGL_D_HI   = 2'b11,
    RGL_D_FALL = 2'b10
  } rgl_dly_e;

  rgl_dly_e    state_r;
  rgl_dly_e    state_nxt;
  logic [31:0] cnt_r;
  logic [31:0] target;
  logic        hit;

  // code is read live, so a rewrite mid-wait retimes the edge
  assign target = (state_r == RGL_D_FALL) ?
                  32'(rgl_dly_ms(fall_code) * MS_CYCLES) :
                  32'(rgl_dly_ms(rise_code) * MS_CYCLES);
  assign hit    = (cnt_r + 32'h1) >= target;

  // a glitch shorter than the delay is swallowed, not passed on
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      RGL_D_LO:   if (lvl_in) state_nxt = RGL_D_RISE;
      RGL_D_RISE: begin
        if (!lvl_in) state_nxt = RGL_D_LO;
        else if (hit) state_nxt = RGL_D_HI;
      end
      RGL_D_HI:   if (!lvl_in) state_nxt = RGL_D_FALL;
      RGL_D_FALL: begin
        if (lvl_in) state_nxt = RGL_D_HI;
        else if (hit) state_nxt = RGL_D_LO;
      end
      default:    state_nxt = RGL_D_LO;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= RGL_D_LO;
      cnt_r   <= 32'h0;
      lvl_out <= 1'b0;
      pending <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= (state_nxt != state_r) ? 32'h0 : cnt_r + 32'h1;
      lvl_out <= (state_nxt == RGL_D_HI) || (state_nxt == RGL_D_FALL);
      pending <= (state_nxt == RGL_D_RISE) || (state_nxt == RGL_D_FALL);
    end
  end

endmodule : rgl_edge_delay

// file: core/rgl_rail_enable.sv
// Function
// - Rail four takes its enable from the pin picked by a 3-bit code.
// - Code 111 feeds a constant one, enabling the rail with no pin.
// - Rail five has its own selector with the same code-to-pin table.
// - Per rail, a mask bit drops the switch-two/ldo-one pair good.
// - Per rail, a mask bit drops the switch-one good signal.
// - Rail five has eight good mask bits, 0 keeps and 1 drops each.
// - Rail four's falling enable edge is delayed by a 3-bit code.
// - Rail four's rising enable edge is delayed by a separate code.
// - Rail four has eight good mask bits, 0 keeps and 1 drops each.
// - Rail five has its own rise and fall delays, same table.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module rgl_rail_enable
  import rgl_pkg::*;
#(
  parameter int unsigned MS_CYCLES = RGL_MS_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire rgl_ctl_t    control_input,
  input  wire rgl_pg_s     power_good,
  output logic             step_down_rail_four,
  output logic             step_down_rail_five
);

  // stored registers, three per rail: mask, source, delay
  logic [7:0] reg_r [RGL_NREG];

  logic [7:0]  word_idx;
  logic        aligned;
  logic        in_stored;
  logic        is_stat;
  logic        is_blk4;
  logic        is_blk5;
  logic        mapped;
  logic [2:0]  slot;
  logic        setup;
  logic        access_done;
  logic        wr_go;
  logic [7:0]  rd_byte;

  logic [1:0]  rail_en;
  logic [1:0]  rail_pend;
  logic [1:0]  src_lvl;
  logic [1:0]  gate_ok;
  logic [1:0]  gate_lvl;
  logic [9:0]  blk [2];

  // control pin picked by a source code, shared by both rails
  function automatic logic src_pick(input logic [2:0] code,
                                    input rgl_ctl_t   ctl);
    case (code)
      RGL_SRC_CONTROL_INPUT_ONE:  src_pick = ctl[0];
      RGL_SRC_CONTROL_INPUT_TWO:  src_pick = ctl[1];
      RGL_SRC_CONTROL_INPUT_FIVE:  src_pick = ctl[4];
      RGL_SRC_CONTROL_INPUT_FOUR:  src_pick = ctl[3];
      RGL_SRC_CONTROL_INPUT_THREE:  src_pick = ctl[2];
      RGL_SRC_CTL34: src_pick = ctl[2] & ctl[3];
      RGL_SRC_CONTROL_INPUT_SIX:  src_pick = ctl[5];
      RGL_SRC_FORCE: src_pick = 1'b1;
      default:       src_pick = 1'b0;
    endcase
  endfunction : src_pick

  // the eight goods in mask-bit order, own rail left out
  function automatic logic [7:0] good_vec(input rgl_pg_s pg,
                                          input logic    rail5);
    good_vec = {pg.ldo3, pg.ldo2, pg.sw_a1, pg.rail6,
                rail5 ? pg.rail4 : pg.rail5,
                pg.rail3, pg.rail2, pg.rail1};
  endfunction : good_vec

  // function for the reset value of each stored slot
  function automatic logic [7:0] rst_val(input int unsigned n);
    case (n)
      0:       rst_val = RGL_RST_R4_MASK;
      1:       rst_val = RGL_RST_R4_SRC;
      2:       rst_val = RGL_RST_R4_DLY;
      3:       rst_val = RGL_RST_R5_MASK;
      4:       rst_val = RGL_RST_R5_SRC;
      default: rst_val = RGL_RST_R5_DLY;
    endcase
  endfunction : rst_val

  // address decode
  assign word_idx  = paddr[9:2];
  assign aligned   = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
  assign in_stored = (word_idx >= RGL_IDX_R4_MASK) &&
                     (word_idx <= RGL_IDX_R5_DLY);
  assign is_stat   = word_idx == RGL_IDX_STAT;
  assign is_blk4   = word_idx == RGL_IDX_R4_BLK;
  assign is_blk5   = word_idx == RGL_IDX_R5_BLK;
  assign mapped    = aligned && (in_stored || is_stat || is_blk4 ||
                     is_blk5);
  assign slot      = 3'(word_idx - RGL_IDX_R4_MASK);

  // one wait-free access: pready rises in the cycle after setup
  assign setup       = psel && !penable;
  assign access_done = psel && penable && pready;
  // only byte lane 0 carries data; read-only words ignore writes
  assign wr_go       = access_done && pwrite && pstrb[0] &&
                       aligned && in_stored;

  assign rd_byte = !aligned  ? 8'h00 :
                   in_stored ? reg_r[slot] :
                   is_stat   ? {2'b00, rail_pend, gate_ok, rail_en} :
                   is_blk4   ? blk[0][7:0] :
                   is_blk5   ? blk[1][7:0] : 8'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      prdata  <= (setup && !pwrite) ? {24'h0, rd_byte} : 32'h0;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < RGL_NREG; gi++) begin : g_reg
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          reg_r[gi] <= rst_val(gi);
        end else if (wr_go && (slot == 3'(gi))) begin
          reg_r[gi] <= pwdata[7:0];
        end
      end
    end
  endgenerate

  generate
    for (gi = 0; gi < 2; gi++) begin : g_rail
      logic [7:0] mask8;
      logic [7:0] srcreg;
      logic [7:0] dlyreg;
      logic [7:0] goods;

      assign mask8  = reg_r[gi * RGL_REGS_RAIL];
      assign srcreg = reg_r[gi * RGL_REGS_RAIL + 1];
      assign dlyreg = reg_r[gi * RGL_REGS_RAIL + 2];
      assign goods  = good_vec(power_good, gi == 1);

      // same decode for both rails
      assign src_lvl[gi] = src_pick(
        srcreg[RGL_SRC_LSB +: 3], control_input);

      // a low good blocks only where its mask bit is 0
      assign blk[gi] = {
        !power_good.pair  && !srcreg[RGL_PAIR_BIT],
        !power_good.sw_b1 && !srcreg[RGL_LOAD_SWITCH_B_ONE_BIT],
        ~goods & ~mask8};

      assign gate_ok[gi]  = ~|blk[gi];
      assign gate_lvl[gi] = src_lvl[gi] && gate_ok[gi];

      // code 110 maps to 32 ms like every other rail
      rgl_edge_delay #(
        .MS_CYCLES (MS_CYCLES)
      ) u_dly (
        .pclk      (pclk),
        .presetn   (presetn),
        .lvl_in    (gate_lvl[gi]),
        .rise_code (dlyreg[RGL_RISE_LSB +: 3]),
        .fall_code (dlyreg[RGL_FALL_LSB +: 3]),
        .lvl_out   (rail_en[gi]),
        .pending   (rail_pend[gi])
      );
    end
  endgenerate

  // enables leave straight from the delay flops
  assign step_down_rail_four = rail_en[0];
  assign step_down_rail_five = rail_en[1];

endmodule : rgl_rail_enable

// file: dv/rgl_rail_enable_props.sv
`timescale 1ns/1ps
module rgl_rail_enable_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_acc; psel && penable && pready; endsequence
  sequence s_bad; s_setup ##0 (paddr[1:0] != 2'h0); endsequence
  property p_ans; s_setup |=> s_acc; endproperty
  a_ans: assert property (p_ans) else $error("setup not answered");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("ready held");
  property p_acc; pready |-> psel && penable && $past(psel); endproperty
  a_acc: assert property (p_acc) else $error("stray ready");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("stray error");
  property p_hi; pready |-> prdata[31:8] == 24'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper data set");
  property p_idle; !pready |-> prdata == 32'h0 && !pslverr; endproperty
  a_idle: assert property (p_idle) else $error("answer when idle");
  property p_wr; pready && pwrite |-> prdata == 32'h0; endproperty
  a_wr: assert property (p_wr) else $error("data on write");
  property p_bad; s_bad |=> s_acc ##0 pslverr; endproperty
  a_bad: assert property (p_bad) else $error("unaligned accepted");
endmodule : rgl_rail_enable_props

bind rgl_rail_enable rgl_rail_enable_props u_props (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr));

// file: dv/rgl_far_model.sv
`timescale 1ns/1ps
module rgl_far_model
  import rgl_pkg::*;
(
  input  wire logic     pclk,
  input  wire logic     presetn,
  input  wire rgl_ctl_t ctl_req,
  input  wire rgl_pg_s  pg_req,
  output rgl_ctl_t      control_input,
  output rgl_pg_s       power_good
);
  // pins move one edge after the request, like a clocked controller
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_input <= '0;
      power_good    <= '0;
    end else begin
      control_input <= ctl_req;
      power_good    <= pg_req;
    end
  end
endmodule : rgl_far_model

// file: dv/rgl_rail_enable_tb_top.sv
`timescale 1ns/1ps
module rgl_rail_enable_tb_top
  import rgl_pkg::*;
;
  localparam int MSC = 4;
  logic        pclk, presetn, psel, penable, pwrite, pready, slv, e4, e5, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  rgl_ctl_t    ctl, ci;
  rgl_pg_s     pg, pgw;
  int          err_total, check_count, cyc, n4, n5, nn, seed = 22044;
  logic [8:0]  b4, b5;
  int          m[6] = '{0, 'h80, 0, 0, 0, 0};
  int          dt[8] = '{0, 2, 4, 8, 16, 24, 32, 64};
  rgl_far_model u_far (.pclk(pclk), .presetn(presetn), .ctl_req(ctl),
    .pg_req(pg), .control_input(ci), .power_good(pgw));
  rgl_rail_enable #(.MS_CYCLES(MSC)) DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(slv), .control_input(ci), .power_good(pgw),
    .step_down_rail_four(e4), .step_down_rail_five(e5));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task test_done;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      test_done();
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk
  // request stands until pready is seen high at a rising edge
  task apb(input logic w, input int a, input int d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= 12'(a);
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no wait count assumed; only the bench timeout ends this
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = slv;
    @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
    if (w && pstrb[0] && !er && a >= 'h40 && a <= 'h54)
      m[a / 4 - 16] = d & 'hff;
  endtask : apb
  task rdall;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 64 + 4 * i, 0);
      chk(rd, m[i]);
      chk(er, 1'b0);
    end
  endtask : rdall
  // gate ok on top, then the eight blocking goods of rail r
  function automatic logic [8:0] pgv(input int r);
    logic [7:0]  c, k, g;
    logic [10:0] p;
    c = 8'(m[r * 3 + 1]);
    k = 8'(m[r * 3]);
    p = pg;
    g = r ? {p[8:5], p[3:0]} : {p[8:4], p[2:0]};
    pgv = {(&(g | k)) & (p[10] | c[1]) & (p[9] | c[0]), ~g & ~k};
  endfunction : pgv
  function automatic logic gate(input int r);
    logic [7:0] c, sv;
    logic [8:0] ok;
    c = 8'(m[r * 3 + 1]);
    sv = {1'b1, ctl[5], ctl[2] & ctl[3], ctl[2], ctl[3], ctl[4], ctl[1],
          ctl[0]};
    ok = pgv(r);
    gate = sv[c[4:2]] & ok[8];
  endfunction : gate
  task dchk(input int d, input logic v);
    nn = dt[d] * MSC > 0 ? dt[d] * MSC : 1;
    @(posedge pclk);
    ctl <= {5'h0, v};
    n4 = -1;
    n5 = -1;
    for (int k = 0; k < 400 && (n4 < 0 || n5 < 0); k++) begin
      @(negedge pclk);
      if (n4 < 0 && e4 === v) n4 = k;
      if (n5 < 0 && e5 === v) n5 = k;
    end
    chk(n4 >= nn - 1 && n4 <= nn + 4, 1'b1);
    chk(n5, n4);
  endtask : dchk
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hf;
    ctl = '0;
    pg = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdall();
    apb(1'b0, 'hc0, 0);
    chk(er, 1'b1);
    apb(1'b0, 'h42, 0);
    chk(er, 1'b1);
    apb(1'b1, 'h80, 'hff);
    chk(er, 1'b0);
    for (int i = 0; i < 40; i++) begin
      apb(1'b1, 'h40, $random(seed));
      apb(1'b1, 'h44, $random(seed) & 'he3 | i % 8 * 4);
      apb(1'b1, 'h4c, $random(seed));
      apb(1'b1, 'h50, $random(seed) & 'he3 | (i + 3) % 8 * 4);
      ctl <= 6'($random(seed));
      pg  <= 11'($random(seed) | $random(seed));
      repeat (6) @(negedge pclk);
      chk(e4, gate(0));
      chk(e5, gate(1));
      b4 = pgv(0);
      b5 = pgv(1);
      apb(1'b0, 'h80, 0);
      chk(rd, {28'h0, b5[8], b4[8], gate(1), gate(0)});
      apb(1'b0, 'h84, 0);
      chk(rd, {24'h0, b4[7:0]});
      apb(1'b0, 'h88, 0);
      chk(rd, {24'h0, b5[7:0]});
    end
    pstrb <= 4'he;
    apb(1'b1, 'h48, 'h3f);
    pstrb <= 4'hf;
    rdall();
    apb(1'b1, 'h40, 'hff);
    apb(1'b1, 'h44, 3);
    apb(1'b1, 'h4c, 'hff);
    apb(1'b1, 'h50, 3);
    pg  <= '1;
    ctl <= '0;
    repeat (8) @(posedge pclk);
    for (int d = 0; d < 8; d++) begin
      apb(1'b1, 'h48, d * 9);
      apb(1'b1, 'h54, d * 9);
      dchk(d, 1'b1);
      dchk(d, 1'b0);
    end
    // a short pulse on the pin must be swallowed by the long delay
    ctl <= 6'h01;
    repeat (3) @(posedge pclk);
    ctl <= 6'h00;
    repeat (300) @(negedge pclk);
    chk({e4, e5}, 2'b00);
    test_done();
  end
endmodule : rgl_rail_enable_tb_top
